// file: logic/itd_cfg.svh
`ifndef ITD_CFG_SVH
`define ITD_CFG_SVH

// ****************************************************************
// Word layout
// ****************************************************************
`define ITD_WORD_W 14
`define ITD_F_MSB 6
`define ITD_F_LSB 0
`define ITD_D_BIT 7
`define ITD_B_MSB 9
`define ITD_B_LSB 7
`define ITD_K_MSB 10
`define ITD_N_BIT 2
`define ITD_MM_MSB 1
`define ITD_MM_LSB 0

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define ITD_TOP_BYTE 2'h0
`define ITD_TOP_BIT 2'h1
`define ITD_TOP_JMP 2'h2
`define ITD_TOP_LIT 2'h3
`define ITD_CTL_HI 7'h00
`define ITD_DECSKIP 6'h0B
`define ITD_INCSKIP 6'h0F
`define ITD_BITSKIP_HI 3'h3
`define ITD_BRLIT_HI 5'h19
`define ITD_RETLIT_HI 6'h34
`define ITD_IND_MOVE_HI 10'h001
`define ITD_OP_RETURN 14'h0008
`define ITD_OP_INTRET 14'h0009
`define ITD_OP_CALLACC 14'h000A
`define ITD_OP_BRACC 14'h000B
`define ITD_IND_ADDR_HI 6'h00
`define ITD_LITF_A 4'h5
`define ITD_LITF_B 4'h6
`define ITD_LITF_C 4'h7
`define ITD_LITF_D 4'hB
`define ITD_LITF_E 4'hD

// ****************************************************************
// Timing
// ****************************************************************
`define ITD_CLK_NS 25
`define ITD_Q_LAST 2'h3
`define ITD_Q_FETCH 2'h2
`define ITD_Q_READ 2'h0
`define ITD_CYC_ONE 2'h1
`define ITD_CYC_TWO 2'h2

`endif

// file: logic/itd_pkg.sv
`default_nettype none

package itd_pkg;

    // Operation group
    typedef enum logic [1:0] {
        ITD_GRP_BYTE,
        ITD_GRP_BIT,
        ITD_GRP_LITCTL
    } itd_grp_t;

    // Timing behaviour of an operation
    typedef enum logic [1:0] {
        ITD_KIND_PLAIN,
        ITD_KIND_SKIP,
        ITD_KIND_FLOW,
        ITD_KIND_INDMOVE
    } itd_kind_t;

    // Decoded word
    typedef struct packed {
        itd_grp_t grp;
        itd_kind_t kind;
        logic file_op;
        logic wr_file;
        logic wr_acc;
    } itd_dec_t;

endpackage

`default_nettype wire

// file: logic/itd_decoder.sv
// Overview of operation
// - Each instruction is one 14-bit word
// - Sort into byte, bit, literal/control groups
// - Other instructions take one instruction cycle
// - Both call forms take two cycles
// - All three returns take two cycles
// - Jumps, branches and taken skips take two cycles
// - Skip extra cycle only when taken, as no-op
// - Indirect access to program memory adds cycle
// - Instruction cycle is four clocks
// - File operands are read, modified, written back
// - File read happens even for write-only ops
// - File address selects 0x00 to 0x7F
// - Bit field picks bit of 8-bit register
// - Don't-care bits are not opcode bits, but clear-W bits 6:0 still form a file address and file 0 or 1 can add an indirect cycle
// - Destination bit steers result to W or file
// - Pointer field selects pair 0 or 1
// - Two-bit pre/post increment/decrement mode
`include "itd_cfg.svh"
`default_nettype none

module itd_decoder (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Program memory
    output logic fetch_ff,
    input wire logic [`ITD_WORD_W-1:0] instr_word,
    // Execution feedback
    input wire logic skip_taken,
    input wire logic [1:0] ptr_msb,
    // Decoded fields
    output itd_pkg::itd_grp_t grp_ff,
    output logic [6:0] file_addr_ff,
    output logic [2:0] bit_pos_ff,
    output logic [10:0] literal_ff,
    output logic ptr_sel_ff,
    output logic [1:0] ptr_mode_ff,
    output logic dest_file_ff,
    // Timing strobes
    output logic [1:0] q_phase_ff,
    output logic icyc_end_ff,
    output logic nop_cycle_ff,
    output logic file_rd_ff,
    output logic file_wr_ff,
    output logic acc_wr_ff,
    output logic instr_done_ff
);

    // ************************************************************
    // Decode
    // ************************************************************

    // Classify a word; unused x bits are simply never looked at
    function automatic itd_pkg::itd_dec_t itd_decode(
        input logic [`ITD_WORD_W-1:0] w
    );
        itd_pkg::itd_dec_t r;
        r.grp = itd_pkg::ITD_GRP_LITCTL;
        r.kind = itd_pkg::ITD_KIND_PLAIN;
        r.file_op = 1'b0;
        r.wr_file = 1'b0;
        r.wr_acc = 1'b0;
        unique case (w[13:12])
            `ITD_TOP_BYTE: begin
                if (w[13:7] == `ITD_CTL_HI) begin
                    if (w[13:4] == `ITD_IND_MOVE_HI) begin
                        r.kind = itd_pkg::ITD_KIND_INDMOVE;
                    end else if (w == `ITD_OP_RETURN ||
                                 w == `ITD_OP_INTRET) begin
                        r.kind = itd_pkg::ITD_KIND_FLOW;
                    end else if (w == `ITD_OP_CALLACC ||
                                 w == `ITD_OP_BRACC) begin
                        r.kind = itd_pkg::ITD_KIND_FLOW;
                    end
                end else begin
                    r.grp = itd_pkg::ITD_GRP_BYTE;
                    r.file_op = 1'b1;
                    r.wr_file = w[`ITD_D_BIT];
                    r.wr_acc = ~w[`ITD_D_BIT];
                    if (w[13:8] == `ITD_DECSKIP ||
                        w[13:8] == `ITD_INCSKIP) begin
                        r.kind = itd_pkg::ITD_KIND_SKIP;
                    end
                end
            end
            `ITD_TOP_BIT: begin
                r.grp = itd_pkg::ITD_GRP_BIT;
                r.file_op = 1'b1;
                if (w[13:11] == `ITD_BITSKIP_HI) begin
                    r.kind = itd_pkg::ITD_KIND_SKIP;
                end else begin
                    r.wr_file = 1'b1;
                end
            end
            `ITD_TOP_JMP: begin
                r.kind = itd_pkg::ITD_KIND_FLOW;
            end
            `ITD_TOP_LIT: begin
                // Shifts and carry arithmetic are file ops in this space
                if (w[11:8] inside {`ITD_LITF_A, `ITD_LITF_B, `ITD_LITF_C,
                                    `ITD_LITF_D, `ITD_LITF_E}) begin
                    r.grp = itd_pkg::ITD_GRP_BYTE;
                    r.file_op = 1'b1;
                    r.wr_file = w[`ITD_D_BIT];
                    r.wr_acc = ~w[`ITD_D_BIT];
                end else if (w[13:9] == `ITD_BRLIT_HI ||
                    w[13:8] == `ITD_RETLIT_HI) begin
                    r.kind = itd_pkg::ITD_KIND_FLOW;
                end
            end
        endcase
        return r;
    endfunction

    itd_pkg::itd_dec_t dec_in;
    logic ind_sel;
    logic ind_extra;
    logic [1:0] base_cyc;

    // Decode the word on the bus; only used on the latch edge
    always_comb begin
        dec_in = itd_decode(instr_word);
        if (dec_in.kind == itd_pkg::ITD_KIND_INDMOVE) begin
            ind_sel = instr_word[`ITD_N_BIT];
        end else begin
            ind_sel = instr_word[0];
        end
        // File 0 or 1 is the indirect register of that pointer
        ind_extra = ptr_msb[ind_sel] &
            ((dec_in.file_op &&
              instr_word[6:1] == `ITD_IND_ADDR_HI) ||
             dec_in.kind == itd_pkg::ITD_KIND_INDMOVE);
        if (dec_in.kind == itd_pkg::ITD_KIND_FLOW) begin
            base_cyc = `ITD_CYC_TWO;
        end else begin
            base_cyc = `ITD_CYC_ONE;
        end
    end

    // ************************************************************
    // Sequencing
    // ************************************************************

    typedef enum logic {
        ST_BOOT,
        ST_EXEC
    } itd_state_t;

    itd_state_t state_ff;
    itd_pkg::itd_kind_t kind_ff;
    logic file_op_ff;
    logic wr_file_ff;
    logic wr_acc_ff;
    logic [1:0] cyc_idx_ff;
    logic [1:0] cyc_tot_ff;
    logic last_cyc;
    logic latch;

    assign last_cyc = (2'(cyc_idx_ff + 2'h1) == cyc_tot_ff);
    // The word is taken on the edge that ends the fetch strobe
    assign latch = fetch_ff;

    // State and quarter phase; a cycle is always four clocks
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_ff <= ST_BOOT;
            q_phase_ff <= 2'h0;
        end else if (latch) begin
            state_ff <= ST_EXEC;
            q_phase_ff <= 2'h0;
        end else if (state_ff == ST_EXEC) begin
            q_phase_ff <= 2'(q_phase_ff + 2'h1);
        end
    end

    // Fetch strobe: overlaps Q4 of the final cycle so no clocks
    // are lost between instructions
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            fetch_ff <= 1'b0;
        end else if (state_ff == ST_BOOT) begin
            fetch_ff <= ~fetch_ff;
        end else begin
            fetch_ff <= (q_phase_ff == `ITD_Q_FETCH) && last_cyc;
        end
    end

    // Cycle budget; a taken skip extends it after the Q2 sample
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cyc_idx_ff <= 2'h0;
            cyc_tot_ff <= `ITD_CYC_ONE;
        end else if (latch) begin
            cyc_idx_ff <= 2'h0;
            cyc_tot_ff <= 2'(base_cyc + {1'b0, ind_extra});
        end else if (state_ff == ST_EXEC) begin
            if (q_phase_ff == `ITD_Q_LAST) begin
                cyc_idx_ff <= 2'(cyc_idx_ff + 2'h1);
            end
            if (q_phase_ff == 2'h1 && cyc_idx_ff == 2'h0 &&
                kind_ff == itd_pkg::ITD_KIND_SKIP && skip_taken) begin
                cyc_tot_ff <= 2'(cyc_tot_ff + 2'h1);
            end
        end
    end

    // Register the fields; positions fixed by the group layout
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            grp_ff <= itd_pkg::ITD_GRP_LITCTL;
            kind_ff <= itd_pkg::ITD_KIND_PLAIN;
            file_op_ff <= 1'b0;
            wr_file_ff <= 1'b0;
            wr_acc_ff <= 1'b0;
            file_addr_ff <= 7'h00;
            bit_pos_ff <= 3'h0;
            literal_ff <= 11'h000;
            ptr_sel_ff <= 1'b0;
            ptr_mode_ff <= 2'h0;
            dest_file_ff <= 1'b0;
        end else if (latch) begin
            grp_ff <= dec_in.grp;
            kind_ff <= dec_in.kind;
            file_op_ff <= dec_in.file_op;
            wr_file_ff <= dec_in.wr_file;
            wr_acc_ff <= dec_in.wr_acc;
            file_addr_ff <= instr_word[`ITD_F_MSB:`ITD_F_LSB];
            bit_pos_ff <= instr_word[`ITD_B_MSB:`ITD_B_LSB];
            literal_ff <= instr_word[`ITD_K_MSB:0];
            ptr_sel_ff <= ind_sel;
            ptr_mode_ff <= instr_word[`ITD_MM_MSB:`ITD_MM_LSB];
            dest_file_ff <= dec_in.wr_file;
        end
    end

    // ************************************************************
    // Strobes
    // ************************************************************

    // Q-phase strobes, set one clock ahead so they leave flops
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            icyc_end_ff <= 1'b0;
            instr_done_ff <= 1'b0;
            file_rd_ff <= 1'b0;
            file_wr_ff <= 1'b0;
            acc_wr_ff <= 1'b0;
        end else begin
            icyc_end_ff <= (state_ff == ST_EXEC) && !latch &&
                (q_phase_ff == `ITD_Q_FETCH);
            instr_done_ff <= (state_ff == ST_EXEC) && !latch &&
                (q_phase_ff == `ITD_Q_FETCH) && last_cyc;
            // Read even when the op only writes: reads have effects
            file_rd_ff <= (state_ff == ST_EXEC) && !latch &&
                file_op_ff && cyc_idx_ff == 2'h0 &&
                q_phase_ff == `ITD_Q_READ;
            file_wr_ff <= (state_ff == ST_EXEC) && !latch &&
                wr_file_ff && last_cyc &&
                q_phase_ff == `ITD_Q_FETCH;
            acc_wr_ff <= (state_ff == ST_EXEC) && !latch &&
                wr_acc_ff && last_cyc &&
                q_phase_ff == `ITD_Q_FETCH;
        end
    end

    // Only the second cycle of a taken skip or flow change is flagged
    // as a no-op; an indirect extra cycle is not flagged as a no-op
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            nop_cycle_ff <= 1'b0;
        end else if (latch) begin
            nop_cycle_ff <= 1'b0;
        end else if (state_ff == ST_EXEC &&
                     q_phase_ff == `ITD_Q_LAST) begin
            nop_cycle_ff <= cyc_idx_ff == 2'h0 &&
                (kind_ff == itd_pkg::ITD_KIND_FLOW ||
                 (kind_ff == itd_pkg::ITD_KIND_SKIP &&
                  skip_taken));
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    a_phase_wrap: assert property (
        state_ff == ST_EXEC && q_phase_ff == `ITD_Q_LAST
        |=> q_phase_ff == 2'h0)
        else $error("phase did not wrap after Q4");

    a_cycle_four: assert property (
        icyc_end_ff |=> !icyc_end_ff [*3] ##1 icyc_end_ff)
        else $error("instruction cycle not four clocks");

    a_fetch_last: assert property (
        fetch_ff && state_ff == ST_EXEC
        |-> q_phase_ff == `ITD_Q_LAST && last_cyc)
        else $error("fetch before cycles elapsed");

    a_plain_one: assert property (
        latch && dec_in.kind == itd_pkg::ITD_KIND_PLAIN && !ind_extra
        |-> ##4 instr_done_ff)
        else $error("plain op not one cycle");

    a_flow_two: assert property (
        latch && dec_in.kind == itd_pkg::ITD_KIND_FLOW && !ind_extra
        |-> ##4 !instr_done_ff ##4 instr_done_ff)
        else $error("flow op not two cycles");

    a_ind_extra: assert property (
        latch && dec_in.kind == itd_pkg::ITD_KIND_PLAIN && ind_extra
        |-> ##4 !instr_done_ff ##4 instr_done_ff)
        else $error("indirect access lacks extra cycle");

    a_skip_len: assert property (
        latch && dec_in.kind == itd_pkg::ITD_KIND_SKIP && !ind_extra
        ##2 !skip_taken |-> ##2 instr_done_ff)
        else $error("untaken skip not one cycle");

    a_read_first: assert property (
        latch && dec_in.file_op |-> ##2 file_rd_ff)
        else $error("file operand not read");

    a_dest_steer: assert property (
        (file_wr_ff |-> dest_file_ff) and (acc_wr_ff |-> !dest_file_ff))
        else $error("result steered to wrong place");

    a_nop_kind: assert property (
        nop_cycle_ff |-> kind_ff inside {itd_pkg::ITD_KIND_SKIP,
                                         itd_pkg::ITD_KIND_FLOW})
        else $error("no-op cycle on wrong op");

    c_skip_taken: cover property (
        kind_ff == itd_pkg::ITD_KIND_SKIP && nop_cycle_ff);
    c_ind_extra: cover property (latch && ind_extra);
    c_flow_done: cover property (
        kind_ff == itd_pkg::ITD_KIND_FLOW && instr_done_ff);

endmodule

`default_nettype wire

// file: test/itd_mem_model.sv
`include "itd_cfg.svh"
`default_nettype none

// ****************************************************************
// Program memory and pointer state seen by the decoder
// ****************************************************************
module itd_mem_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Fetch side
    input wire logic fetch_ff,
    output logic [`ITD_WORD_W-1:0] instr_word,
    // Execution feedback
    output logic skip_taken,
    output logic [1:0] ptr_msb
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [13:0] mem [256];
    logic skp [256];
    logic [1:0] ptr [256];
    logic [7:0] pc_ff;
    logic skip_ff;

    // Word is only good while a fetch is asked; otherwise the bus shows
    // the inverse, so a sample at the wrong edge reads a wrong word
    assign instr_word = fetch_ff ? mem[pc_ff] : ~mem[pc_ff];
    assign ptr_msb = fetch_ff ? ptr[pc_ff] : ~ptr[pc_ff];
    assign skip_taken = skip_ff;

    // Address steps on each taken fetch; skip outcome held per word
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pc_ff <= 8'h00;
            skip_ff <= 1'b0;
        end else if (fetch_ff) begin
            pc_ff <= pc_ff + 8'h01;
            skip_ff <= skp[pc_ff];
        end
    end
endmodule

`default_nettype wire

// file: test/testbench.sv
`include "itd_cfg.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Signals
    // ************************************************************
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic fetch_ff, skip_taken, ptr_sel_ff, dest_file_ff, icyc_end_ff;
    logic nop_cycle_ff, file_rd_ff, file_wr_ff, acc_wr_ff, instr_done_ff;
    logic [`ITD_WORD_W-1:0] instr_word;
    logic [1:0] ptr_msb, ptr_mode_ff, q_phase_ff;
    logic [6:0] file_addr_ff;
    logic [2:0] bit_pos_ff;
    logic [10:0] literal_ff;
    itd_pkg::itd_grp_t grp_ff;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0, ninstr = 0, cnt = 0, nnop = 0, nx = 0, k = 0;
    logic act = 1'b0;
    logic [13:0] w;
    logic [8:0] e;
    logic [13:0] cw [5] = '{14'h0B81, 14'h0080, 14'h1C05, 14'h0016, 14'h0103};
    logic [2:0] cs [5] = '{3'h6, 3'h1, 3'h3, 3'h2, 3'h7};

    // Half-period toggle gives 40 MHz
    always #12.5 clk_sys = ~clk_sys;

    itd_decoder DUT (.clk_sys, .resetn, .fetch_ff, .instr_word, .skip_taken,
        .ptr_msb, .grp_ff, .file_addr_ff, .bit_pos_ff, .literal_ff,
        .ptr_sel_ff, .ptr_mode_ff, .dest_file_ff, .q_phase_ff, .icyc_end_ff,
        .nop_cycle_ff, .file_rd_ff, .file_wr_ff, .acc_wr_ff, .instr_done_ff);

    itd_mem_model u_mem (.clk_sys, .resetn, .fetch_ff, .instr_word,
        .skip_taken, .ptr_msb);

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic chk_bit(input string n, input logic ex, input logic got);
        cmp_count++;
        if (got !== ex) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", n, ex, got);
        end
    endtask

    task automatic chk_vec(input string n, input logic [13:0] ex,
                           input logic [13:0] got);
        cmp_count++;
        if (got !== ex) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, ex, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Packs {cycles, group, nop, file op, file write, W write, ind move}
    function automatic logic [8:0] expect_of(input logic [13:0] w,
                                             input logic s,
                                             input logic [1:0] p);
        logic [1:0] n, g;
        logic nop, fo, wf, wa, im, sk, ind;
        g = itd_pkg::ITD_GRP_LITCTL;
        {nop, fo, wf, wa, sk} = 5'h00;
        im = (w[13:4] == 10'h001);
        if (w[13:12] == 2'b01) begin
            g = itd_pkg::ITD_GRP_BIT;
            {fo, sk, wf} = {1'b1, w[11], !w[11]};
        end else if ((w[13:12] == 2'b00 && w[13:7] != 7'h00) ||
                (w[13:12] == 2'b11 &&
                 w[11:8] inside {4'h5, 4'h6, 4'h7, 4'hB, 4'hD})) begin
            g = itd_pkg::ITD_GRP_BYTE;
            {fo, wf, wa} = {1'b1, w[7], !w[7]};
            sk = (w[13:8] == 6'h0B || w[13:8] == 6'h0F);
        end else if (w[13:12] == 2'b10 || w[13:9] == 5'h19 ||
                     w[13:8] == 6'h34 || w[13:2] == 12'h002)
            nop = 1'b1;
        if (sk && s)
            nop = 1'b1;
        ind = (fo && w[6:1] == 6'h00 && p[w[0]]) || (im && p[w[2]]);
        n = 2'h1 + 2'(nop) + 2'(ind);
        return {n, g, nop, fo, wf, wa, im};
    endfunction

    // Random word from the known layouts, INDIRECT_ACCESS_REGISTER targets now and then
    function automatic logic [13:0] rnd_word();
        logic [13:0] r;
        logic [3:0] bp [5] = '{4'h5, 4'h6, 4'h7, 4'hB, 4'hD};
        logic [3:0] lp [6] = '{4'h0, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE};
        r = 14'($urandom);
        case ($urandom % 10)
            0: r = {2'b00, r[11:8], r[11:8] == 4'h0 ? 1'b1 : r[7], r[6:0]};
            1: r[13:8] = {2'b11, bp[$urandom % 5]};
            2: r[13:12] = 2'b01;
            3: r[13:12] = 2'b10;
            4: r[13:9] = 5'h19;
            5: r[13:8] = 6'h34;
            6: r = 14'h0008 + 14'(r[1:0]);
            7: r[13:4] = 10'h001;
            8: r[13:8] = {2'b11, lp[$urandom % 6]};
            default: r = r[0] ? 14'h0000 : 14'h0064;
        endcase
        if (r[13] == 1'b0 && r[13:4] != 10'h001 && r[13:7] != 7'h00 &&
            $urandom % 2)
            r[6:1] = 6'h00;
        return r;
    endfunction

    task automatic do_reset(input int n);
        resetn <= 1'b0;
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit("rst_fetch", 1'b0, fetch_ff);
        chk_bit("rst_done", 1'b0, instr_done_ff);
        chk_vec("rst_grp", 14'(itd_pkg::ITD_GRP_LITCTL), 14'(grp_ff));
        @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit("boot_fetch", 1'b1, fetch_ff);
    endtask

    // ************************************************************
    // Tracker: every clock is judged against the word in flight
    // ************************************************************
    always @(negedge clk_sys) begin
        if (!resetn)
            act = 1'b0;
        else begin
            if (act) begin
                cnt++;
                chk_vec("q_phase", 14'((cnt - 1) % 4), 14'(q_phase_ff));
                chk_bit("icyc_end", cnt % 4 == 0, icyc_end_ff);
                chk_bit("fetch", cnt == 4 * nx, fetch_ff);
                chk_bit("done", cnt == 4 * nx, instr_done_ff);
                // Indirect moves drive no read/write strobes; they are not checked here
                if (!e[0]) begin
                    chk_bit("file_rd", cnt == 2 && e[3], file_rd_ff);
                    chk_bit("file_wr", cnt == 4 * nx && e[2], file_wr_ff);
                    chk_bit("acc_wr", cnt == 4 * nx && e[1], acc_wr_ff);
                end
                nnop += int'(nop_cycle_ff === 1'b1);
                if (cnt == 1) begin
                    chk_vec("grp", 14'(e[6:5]), 14'(grp_ff));
                    chk_vec("file_addr", 14'(w[6:0]), 14'(file_addr_ff));
                    chk_vec("bit_pos", 14'(w[9:7]), 14'(bit_pos_ff));
                    chk_vec("literal", 14'(w[10:0]), 14'(literal_ff));
                    chk_bit("ptr_sel", e[0] ? w[2] : w[0], ptr_sel_ff);
                    chk_vec("ptr_mode", 14'(w[1:0]), 14'(ptr_mode_ff));
                    if (e[6:5] == 2'(itd_pkg::ITD_GRP_BYTE))
                        chk_bit("dest", w[7], dest_file_ff);
                end
            end
            if (fetch_ff === 1'b1) begin
                if (act)
                    chk_vec("nop_clks", 14'(4 * e[4]), 14'(nnop));
                w = u_mem.mem[u_mem.pc_ff];
                e = expect_of(w, u_mem.skp[u_mem.pc_ff],
                              u_mem.ptr[u_mem.pc_ff]);
                nx = int'(e[8:7]);
                {cnt, nnop, act} = {32'd0, 32'd0, 1'b1};
                ninstr++;
            end
        end
    end

    // Hang guard, well above the few thousand clocks the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 9000) begin
            err_total++;
            final_report();
        end
    end

    // Main sequence: load program, run it, reset mid-run, run again
    initial begin
        void'($urandom(77));
        for (int i = 0; i < 256; i++) begin
            u_mem.mem[i] = rnd_word();
            u_mem.skp[i] = 1'($urandom);
            u_mem.ptr[i] = 2'($urandom);
        end
        // Corners: indirect taken skip, write-only INDIRECT_ACCESS_REGISTER store, untaken
        // skip, indirect move, clear-W with don't-care bits set
        for (int i = 0; i < 5; i++) begin
            u_mem.mem[i] = cw[i];
            {u_mem.skp[i], u_mem.ptr[i]} = cs[i];
        end
        do_reset(10);
        $display("test reset done, mismatches %0d", err_total);
        while (ninstr < 300)
            @(posedge clk_sys);
        $display("test program done, mismatches %0d", err_total);
        @(posedge clk_sys);
        do_reset(3);
        k = ninstr + 40;
        while (ninstr < k)
            @(posedge clk_sys);
        $display("test rerun done, mismatches %0d", err_total);
        final_report();
    end
endmodule

`default_nettype wire
